// File: core/dsd_pkg.sv
// Constants, field layouts and carrier types for the dual synthesizer control block.
// Assumes 24-bit control words, MSB first, with a 3-bit address in the low bits.
package dsd_pkg;

    // ==========================================================
    // Control word layout
    localparam int WORD_W    = 24;
    localparam int ADDR_W    = 3;

    // Word addresses (low three bits of each control word)
    localparam logic [2:0] ADDR_IF_REF_CONTROL_WORD      = 3'h0;
    localparam logic [2:0] ADDR_IF_FEEDBACK_DIVIDE_WORD  = 3'h1;
    localparam logic [2:0] ADDR_IF_SPEEDUP_TIMEOUT_WORD  = 3'h2;
    localparam logic [2:0] ADDR_MAIN_REF_CONFIG_WORD     = 3'h3;
    localparam logic [2:0] ADDR_MAIN_FEEDBACK_WORD       = 3'h4;
    localparam logic [2:0] ADDR_MISC_CONFIG_WORD         = 3'h6;

    // ==========================================================
    // Field positions
    localparam int IF_CLEAR_BIT     = 20;
    localparam int IF_GAIN_BIT      = 19;
    localparam int IF_POL_BIT       = 18;
    localparam int IF_RDIV_LSB      = 3;
    localparam int IF_RDIV_W        = 15;
    localparam int IF_SLEEP_BIT     = 23;
    localparam int IF_FB_LSB        = 3;
    localparam int IF_FB_W          = 17;
    localparam int SWALLOW_W        = 3;
    localparam int MAINCNT_W        = 14;
    localparam int TOC_LSB          = 3;
    localparam int TOC_W            = 14;
    localparam int MREF_LSB         = 10;
    localparam int MREF_W           = 9;
    localparam int DEN_LSB          = 3;
    localparam int DEN_W            = 7;
    localparam int MSLEEP_BIT       = 23;
    localparam int MINT_LSB         = 10;
    localparam int MINT_W           = 13;
    localparam int NUM_LSB          = 3;
    localparam int NUM_W            = 7;
    localparam int SYNC_SEL_BIT     = 8;
    localparam int MREF_RATIO_W     = 16;
    localparam int MN_RATIO_W       = 20;

    // Synchronised pin vector positions
    localparam int PIN_LE           = 0;
    localparam int PIN_IF_EN        = 1;
    localparam int PIN_MAIN_EN      = 2;
    localparam int PIN_IF_REF       = 3;
    localparam int PIN_IF_FB        = 4;
    localparam int PIN_N            = 5;
    localparam logic [PIN_N-1:0] PIN_IDLE = 5'h01; // Only LE idles high

    // ==========================================================
    // Codes and reset values
    localparam logic [13:0] TOC_HIZ        = 14'h0000;
    localparam logic [13:0] TOC_LOW        = 14'h0001;
    localparam logic [13:0] TOC_MANUAL     = 14'h0002;
    localparam logic [13:0] TOC_HIGH       = 14'h0003;
    localparam logic [13:0] TOC_SPEEDUP_MIN = 14'h0004;
    localparam logic [7:0]  DEN_ZERO_VALUE = 8'h80;
    localparam logic [14:0] IF_RDIV_RESET  = 15'h0003;
    localparam logic [16:0] IF_FB_RESET    = 17'h00038;
    localparam logic        IF_SLEEP_RESET = 1'b1;
    localparam logic        MAIN_SLEEP_RESET = 1'b1;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic        pd_polarity;
        logic        pump_gain_select;
        logic        counter_clear;
        logic [14:0] ref_divide;
        logic        sleep_bit;
        logic [16:0] feedback_divide;
        logic [13:0] speedup_timeout;
        logic        sleep_sync_select;
    } dsd_if_cfg_t;

    typedef struct packed {
        logic [8:0]  ref_divide;
        logic [6:0]  frac_den;
        logic [12:0] feedback_int;
        logic [6:0]  frac_num;
        logic        sleep_bit;
    } dsd_main_cfg_t;

    typedef struct packed {
        logic [15:0] ref_ratio;
        logic [19:0] n_ratio;
        logic [6:0]  numerator;
        logic [7:0]  denominator;
        logic        fractional;
    } dsd_main_ratio_t;

endpackage : dsd_pkg

// File: core/dsd_ctrl.sv
// Control logic of the dual synthesizer: serial word capture, secondary loop
// dividers, phase comparator, pump control, speed-up timer and main ratios.
// Assumes the host keeps LE high for at least three ref_clk periods per word.
//
// How it works
// - Polarity bit swaps secondary pump directions.
// - Gain bit selects low or high pump.
// - Speed-up mode overrides the gain bit.
// - Counter clear resets dividers, floats pump.
// - Dividers restart together after reset or sleep.
// - One feedback word powers up and retunes.
// - Feedback word is eight times main plus swallow.
// - Sleep stops dividers, floats feedback input.
// - Reference input floats only when both sleep.
// - Sleeping loop floats pump and comparator.
// - Serial port works in every sleep mode.
// - Synchronous sleep waits for pump pulse end.
// - Asynchronous sleep enters at once.
// - Timeout codes below four disable timer.
// - Larger codes run speed-up for that count.
// - Timeout code sets speed-up pin drive.
// - Integer mode scales both main counters.
// - Main reference ratio follows mode.
// - Integer main ratio is int times den plus num.
// - Mode select picks fractional or integer.
// - Fractional ratio is int plus num over den.
// - Secondary loop runs only if pin high, not sleeping.
`timescale 1ns/1ps
`default_nettype none

module dsd_ctrl (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire logic                    ser_clk,
    input  wire logic                    ser_data,
    input  wire logic                    ser_le,
    input  wire logic                    if_enable_pin,
    input  wire logic                    main_enable_pin,
    input  wire logic                    main_mode_select,
    input  wire logic                    if_ref_input,
    input  wire logic                    if_fb_input,
    output logic                         if_ref_bias_en,
    output logic                         if_fb_bias_en,
    output logic                         if_pump_up,
    output logic                         if_pump_dn,
    output logic                         if_pump_oe,
    output logic                         if_pump_high,
    output logic                         if_speedup_pin_out,
    output logic                         if_speedup_pin_oe,
    output logic                         if_sleep_bit_state,
    output logic                         main_pd_state,
    output logic [dsd_pkg::SWALLOW_W-1:0] if_swallow_count,
    output logic [dsd_pkg::MAINCNT_W-1:0] if_main_count,
    output dsd_pkg::dsd_main_ratio_t     main_ratio
);
    import dsd_pkg::*;

    // ==========================================================
    // Serial shift register, link clock domain
    logic [WORD_W-1:0] shift_reg;
    logic [PIN_N-1:0]  pin_s1_reg;
    logic [PIN_N-1:0]  pin_s2_reg;
    logic [PIN_N-1:0]  pin_prev_reg;
    logic              latch_pulse;
    logic [ADDR_W-1:0] word_addr;

    // Shifts only while LE is low, so the word holds still once LE rises
    always_ff @(posedge ser_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= '0;
        end else if (!ser_le) begin
            shift_reg <= {shift_reg[WORD_W-2:0], ser_data};
        end
    end

    // ==========================================================
    // Pin synchronisers, ref_clk domain
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg   <= PIN_IDLE; // Idle levels, so no false latch after reset
            pin_s2_reg   <= PIN_IDLE;
            pin_prev_reg <= PIN_IDLE;
        end else if (ce) begin
            pin_s1_reg   <= {if_fb_input, if_ref_input, main_enable_pin,
                             if_enable_pin, ser_le};
            pin_s2_reg   <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
        end
    end

    // The word is quasi-static while LE is high, so a plain capture is safe
    assign latch_pulse = pin_s2_reg[PIN_LE] & ~pin_prev_reg[PIN_LE];
    assign word_addr   = shift_reg[ADDR_W-1:0];

    // ==========================================================
    // Control latches
    dsd_if_cfg_t   if_cfg;
    dsd_main_cfg_t main_cfg;

    // Latching never depends on power state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            if_cfg   <= '{1'b0, 1'b0, 1'b0, IF_RDIV_RESET, IF_SLEEP_RESET,
                          IF_FB_RESET, TOC_HIZ, 1'b0};
            main_cfg <= '{9'h001, 7'h01, 13'h0000, 7'h00, MAIN_SLEEP_RESET};
        end else if (ce && latch_pulse) begin
            unique case (word_addr)
                ADDR_IF_REF_CONTROL_WORD: begin
                    if_cfg.pd_polarity      <= shift_reg[IF_POL_BIT];
                    if_cfg.pump_gain_select <= shift_reg[IF_GAIN_BIT];
                    if_cfg.counter_clear    <= shift_reg[IF_CLEAR_BIT];
                    if_cfg.ref_divide       <= shift_reg[IF_RDIV_LSB +: IF_RDIV_W];
                end
                ADDR_IF_FEEDBACK_DIVIDE_WORD: begin
                    // One word carries both sleep and ratio
                    if_cfg.sleep_bit       <= shift_reg[IF_SLEEP_BIT];
                    if_cfg.feedback_divide <= shift_reg[IF_FB_LSB +: IF_FB_W];
                end
                ADDR_IF_SPEEDUP_TIMEOUT_WORD: begin
                    if_cfg.speedup_timeout <= shift_reg[TOC_LSB +: TOC_W];
                end
                ADDR_MAIN_REF_CONFIG_WORD: begin
                    main_cfg.ref_divide <= shift_reg[MREF_LSB +: MREF_W];
                    main_cfg.frac_den   <= shift_reg[DEN_LSB +: DEN_W];
                end
                ADDR_MAIN_FEEDBACK_WORD: begin
                    main_cfg.sleep_bit    <= shift_reg[MSLEEP_BIT];
                    main_cfg.feedback_int <= shift_reg[MINT_LSB +: MINT_W];
                    main_cfg.frac_num     <= shift_reg[NUM_LSB +: NUM_W];
                end
                ADDR_MISC_CONFIG_WORD: begin
                    if_cfg.sleep_sync_select <= shift_reg[SYNC_SEL_BIT];
                end
                default: begin
                    // Address 5 belongs to other logic, 7 is invalid
                end
            endcase
        end
    end

    // ==========================================================
    // Power state
    logic if_sleep_bit_reg;
    logic main_pd_reg;
    logic if_sleep_req;
    logic pump_active;
    logic up_reg;
    logic dn_reg;

    assign if_sleep_req = if_cfg.sleep_bit | ~pin_s2_reg[PIN_IF_EN];
    assign pump_active  = up_reg | dn_reg;

    // Synchronous mode waits for the pump pulse to finish
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            if_sleep_bit_reg <= 1'b1;
        end else if (ce) begin
            if (!if_sleep_req) begin
                if_sleep_bit_reg <= 1'b0;
            end else if (if_cfg.sleep_sync_select && pump_active) begin
                if_sleep_bit_reg <= if_sleep_bit_reg;
            end else begin
                if_sleep_bit_reg <= 1'b1;
            end
        end
    end

    // Main loop sleep only matters here for the shared reference buffer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_pd_reg <= 1'b1;
        end else if (ce) begin
            main_pd_reg <= main_cfg.sleep_bit | ~pin_s2_reg[PIN_MAIN_EN];
        end
    end

    assign if_sleep_bit_state    = if_sleep_bit_reg;
    assign main_pd_state  = main_pd_reg;
    assign if_fb_bias_en  = ~if_sleep_bit_reg;
    assign if_ref_bias_en = ~(if_sleep_bit_reg & main_pd_reg);

    // ==========================================================
    // Secondary dividers
    logic              hold;
    logic              ref_edge;
    logic              fb_edge;
    logic [14:0]       r_cnt_reg;
    logic [16:0]       n_cnt_reg;
    logic [14:0]       r_last;
    logic [16:0]       n_last;
    logic [16:0]       fb_ratio;
    logic              r_done;
    logic              n_done;

    assign hold     = if_sleep_bit_reg | if_cfg.counter_clear;
    assign ref_edge = pin_s2_reg[PIN_IF_REF] & ~pin_prev_reg[PIN_IF_REF];
    assign fb_edge  = pin_s2_reg[PIN_IF_FB] & ~pin_prev_reg[PIN_IF_FB];

    // Swallow count in the low bits, main count above, prescaler of eight
    assign if_swallow_count = if_cfg.feedback_divide[SWALLOW_W-1:0];
    assign if_main_count    = if_cfg.feedback_divide[IF_FB_W-1:SWALLOW_W];
    assign fb_ratio = {if_main_count, 3'h0} + {14'h0000, if_swallow_count};

    // A zero ratio would underflow, so it counts as one
    assign r_last = (if_cfg.ref_divide == '0) ? '0 : if_cfg.ref_divide - 15'h0001;
    assign n_last = (fb_ratio == '0) ? '0 : fb_ratio - 17'h00001;
    assign r_done = ref_edge && !hold && (r_cnt_reg == r_last);
    assign n_done = fb_edge && !hold && (n_cnt_reg == n_last);

    // Both counters sit at zero while held, so they restart in step
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_cnt_reg <= '0;
            n_cnt_reg <= '0;
        end else if (ce) begin
            if (hold) begin
                r_cnt_reg <= '0;
                n_cnt_reg <= '0;
            end else begin
                if (ref_edge) begin
                    r_cnt_reg <= r_done ? '0 : r_cnt_reg + 15'h0001;
                end
                if (fb_edge) begin
                    n_cnt_reg <= n_done ? '0 : n_cnt_reg + 17'h00001;
                end
            end
        end
    end

    // ==========================================================
    // Phase comparator
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
        end else if (ce) begin
            if (hold || (up_reg && dn_reg)) begin
                up_reg <= 1'b0;
                dn_reg <= 1'b0;
            end else begin
                up_reg <= up_reg | r_done;
                dn_reg <= dn_reg | n_done;
            end
        end
    end

    // A negative tuning slope needs the pump directions swapped
    assign if_pump_up = ~hold & (if_cfg.pd_polarity ? up_reg : dn_reg);
    assign if_pump_dn = ~hold & (if_cfg.pd_polarity ? dn_reg : up_reg);
    assign if_pump_oe = ~hold;

    // ==========================================================
    // Speed-up timer
    logic        spd_en;
    logic        spd_active_reg;
    logic [13:0] spd_cnt_reg;
    logic        spd_load;

    assign spd_en   = (if_cfg.speedup_timeout >= TOC_SPEEDUP_MIN);
    assign spd_load = latch_pulse && (word_addr == ADDR_IF_FEEDBACK_DIVIDE_WORD);

    // Counts phase comparisons; a fresh feedback word restarts it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            spd_active_reg <= 1'b0;
            spd_cnt_reg    <= '0;
        end else if (ce) begin
            if (!spd_en) begin
                spd_active_reg <= 1'b0;
                spd_cnt_reg    <= '0;
            end else if (spd_load) begin
                spd_active_reg <= 1'b1;
                spd_cnt_reg    <= if_cfg.speedup_timeout;
            end else if (spd_active_reg && r_done) begin
                spd_cnt_reg <= spd_cnt_reg - 14'h0001;
                if (spd_cnt_reg == 14'h0001) begin
                    spd_active_reg <= 1'b0;
                end
            end
        end
    end

    // Timer owns the gain while enabled; code two forces high gain
    always_comb begin
        if (if_cfg.speedup_timeout == TOC_MANUAL) begin
            if_pump_high = 1'b1;
        end else if (spd_en) begin
            if_pump_high = spd_active_reg;
        end else begin
            if_pump_high = if_cfg.pump_gain_select;
        end
    end

    // Pin drive per timeout code, registered to avoid glitches on the pin
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            if_speedup_pin_out <= 1'b0;
            if_speedup_pin_oe  <= 1'b0;
        end else if (ce) begin
            if (spd_en) begin
                if_speedup_pin_out <= spd_active_reg;
                if_speedup_pin_oe  <= 1'b1;
            end else begin
                if_speedup_pin_out <= (if_cfg.speedup_timeout == TOC_HIGH);
                if_speedup_pin_oe  <= (if_cfg.speedup_timeout != TOC_HIZ);
            end
        end
    end

    // ==========================================================
    // Main loop ratios
    logic [7:0] den_val;

    assign den_val = (main_cfg.frac_den == '0) ? DEN_ZERO_VALUE
                                               : {1'b0, main_cfg.frac_den};

    // Integer mode trades fraction for counter range
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_ratio <= '0;
        end else if (ce) begin
            main_ratio.fractional  <= main_mode_select;
            main_ratio.numerator   <= main_cfg.frac_num;
            main_ratio.denominator <= den_val;
            if (main_mode_select) begin
                main_ratio.ref_ratio <= {7'h00, main_cfg.ref_divide};
                main_ratio.n_ratio   <= {7'h00, main_cfg.feedback_int};
            end else begin
                main_ratio.ref_ratio <= MREF_RATIO_W'(main_cfg.ref_divide * den_val);
                main_ratio.n_ratio   <= MN_RATIO_W'(main_cfg.feedback_int * den_val
                                        + main_cfg.frac_num);
            end
        end
    end

    // ==========================================================
    // Checks
    a_clear_hiz: assert property (@(posedge ref_clk) disable iff (!rst_n)
        if_cfg.counter_clear |-> !if_pump_oe && !if_pump_up && !if_pump_dn)
        else $error("pump driven during counter clear");
    // Counters clear one edge after sleep begins, hence the look back
    a_sleep_float: assert property (@(posedge ref_clk) disable iff (!rst_n)
        if_sleep_bit_reg |-> !if_pump_oe && !if_fb_bias_en
        && (r_cnt_reg == '0 || !$past(if_sleep_bit_reg) || !$past(ce)))
        else $error("secondary loop active while asleep");
    a_ref_buffer: assert property (@(posedge ref_clk) disable iff (!rst_n)
        if_ref_bias_en == !(if_sleep_bit_reg && main_pd_reg))
        else $error("reference buffer state wrong");
    a_pump_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && if_sleep_bit_reg |=> !up_reg && !dn_reg)
        else $error("comparator active in sleep");
    a_async_enter: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && if_sleep_req && !if_cfg.sleep_sync_select |=> if_sleep_bit_reg)
        else $error("asynchronous sleep late");
    a_sync_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && if_sleep_req && if_cfg.sleep_sync_select && pump_active && !if_sleep_bit_reg
        |=> !if_sleep_bit_reg)
        else $error("synchronous sleep cut a pulse");
    a_wake_aligned: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(hold) |-> r_cnt_reg == '0 && n_cnt_reg == '0)
        else $error("dividers not aligned on restart");
    a_gain_normal: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !spd_en && if_cfg.speedup_timeout != TOC_MANUAL
        |-> if_pump_high == if_cfg.pump_gain_select)
        else $error("pump gain ignores select");
    a_gain_speedup: assert property (@(posedge ref_clk) disable iff (!rst_n)
        spd_en |-> if_pump_high == spd_active_reg)
        else $error("speed-up gain wrong");
    a_pin_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && if_cfg.speedup_timeout == TOC_HIGH |=> if_speedup_pin_out && if_speedup_pin_oe)
        else $error("pin not driven high");
    a_timer_expiry: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && spd_en && !spd_load && spd_active_reg && r_done && spd_cnt_reg == 14'h0001
        |=> !spd_active_reg)
        else $error("speed-up did not end on count");
    a_int_ratio: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && !main_mode_select |=> main_ratio.ref_ratio
        == MREF_RATIO_W'($past(main_cfg.ref_divide) * $past(den_val)))
        else $error("integer reference ratio wrong");

    c_sync_sleep: cover property (@(posedge ref_clk) disable iff (!rst_n)
        if_cfg.sleep_sync_select && pump_active ##1 !pump_active ##1 if_sleep_bit_reg);

    c_speedup_end: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(spd_active_reg) && spd_en);

    c_int_mode: cover property (@(posedge ref_clk) disable iff (!rst_n)
        !main_mode_select && main_cfg.frac_den == '0);

endmodule : dsd_ctrl

`default_nettype wire

// File: verif/dsd_host_model.sv
// Serial host model: shifts 24-bit words MSB first on its own link clock.
// Assumes the bench calls send and waits for it to return.
`timescale 1ns/1ps
`default_nettype none
module dsd_host_model (
    output logic ser_clk,
    output logic ser_data,
    output logic ser_le
);
    // ==========================================
    // Idle: clock still, latch high
    initial begin
        ser_clk  = 1'b0;
        ser_data = 1'b0;
        ser_le   = 1'b1;
    end
    // One frame; link clock runs only inside it, 160 ns period
    task automatic send(input logic [23:0] w);
        #13 ser_le = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            #80 ser_clk = 1'b1;
            #80 ser_clk = 1'b0;
        end
        ser_data = ~w[0]; // Inverse of the last bit, so no stale bit
        #80 ser_le = 1'b1;
        #200; // Latch high for at least three system periods
    endtask : send
endmodule : dsd_host_model
`default_nettype wire

// File: verif/dsd_ctrl_tb.sv
// Bench for the dual synthesizer control block, words sent by the host model.
// Assumes dsd_pkg, dsd_ctrl and dsd_host_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module dsd_ctrl_tb;
    import dsd_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n, ce, ser_clk, ser_data, ser_le, if_enable_pin, main_enable_pin;
    logic main_mode_select, if_ref_input, if_fb_input, if_ref_bias_en, if_fb_bias_en;
    logic if_pump_up, if_pump_dn, if_pump_oe, if_pump_high, if_speedup_pin_out;
    logic if_speedup_pin_oe, if_sleep_bit_state, main_pd_state;
    logic [2:0]      if_swallow_count;
    logic [13:0]     if_main_count;
    dsd_main_ratio_t main_ratio;
    logic [2:0]      tgl = 3'h0;
    int              n_mismatch = 0;
    int              n_compared = 0;
    int              seed = 32'h8ae3043c;
    logic [16:0]     fb;
    logic [8:0]      r;
    logic [6:0]      d, f;
    logic [12:0]     n;
    dsd_ctrl dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_le(ser_le), .if_enable_pin(if_enable_pin), .main_enable_pin(main_enable_pin),
        .main_mode_select(main_mode_select), .if_ref_input(if_ref_input),
        .if_fb_input(if_fb_input), .if_ref_bias_en(if_ref_bias_en),
        .if_fb_bias_en(if_fb_bias_en), .if_pump_up(if_pump_up), .if_pump_dn(if_pump_dn),
        .if_pump_oe(if_pump_oe), .if_pump_high(if_pump_high),
        .if_speedup_pin_out(if_speedup_pin_out), .if_speedup_pin_oe(if_speedup_pin_oe),
        .if_sleep_bit_state(if_sleep_bit_state), .main_pd_state(main_pd_state),
        .if_swallow_count(if_swallow_count), .if_main_count(if_main_count),
        .main_ratio(main_ratio));
    dsd_host_model host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));
    // ==========================================
    // Clock and divider inputs, two or more periods per level
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        tgl          <= tgl + 3'h1;
        if_ref_input <= tgl[1];
        if_fb_input  <= tgl[2];
    end
    // ==========================================
    // Helpers
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic put(input logic [23:0] w);
        host.send(w);
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : put
    function automatic dsd_main_ratio_t exp_ratio(input logic fr);
        logic [7:0] dv;
        dv = (d == 7'h00) ? DEN_ZERO_VALUE : {1'b0, d};
        return '{ref_ratio: fr ? 16'(r) : 16'(r) * 16'(dv),
                 n_ratio: fr ? 20'(n) : 20'(n) * 20'(dv) + 20'(f),
                 numerator: f, denominator: dv, fractional: fr};
    endfunction : exp_ratio
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    // Watchdog, far above the longest expected run of about 256 us
    initial begin
        #1_000_000;
        n_mismatch++;
        stop_test();
    end
    // ==========================================
    // Main sequence
    initial begin
        {rst_n, main_mode_select} = 2'b00;
        {ce, if_enable_pin, main_enable_pin} = 3'b111;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("if_sleep_bit_state", if_sleep_bit_state, 1);
        chk("ref_bias", if_ref_bias_en, 0);
        put(24'h000006); // Immediate sleep entry
        for (int g = 0; g < 2; g++) begin
            put({3'h0, 1'b0, g[0], 1'b1, 15'h0004, 3'h0});
            chk("pump_high", if_pump_high, g);
        end
        // Legal ratio from 56 up, kept small so pump pulses end within the run
        fb = 17'd56 + 17'($random(seed) & 16'h00ff);
        put({4'h0, fb, 3'h1});
        chk("swallow", if_swallow_count, fb[2:0]);
        chk("main_cnt", if_main_count, fb[16:3]);
        chk("if_sleep_bit_state", if_sleep_bit_state, 0);
        chk("fb_bias", if_fb_bias_en, 1);
        put({3'h0, 1'b1, 1'b0, 1'b1, 15'h0004, 3'h0});
        chk("pump_oe", if_pump_oe, 0);
        put({3'h0, 1'b0, 1'b0, 1'b1, 15'h0004, 3'h0});
        for (int c = 0; c < 4; c++) begin
            put({7'h00, 14'(c), 3'h2});
            chk("pin_oe", if_speedup_pin_oe, c != 0);
            chk("pin_out", if_speedup_pin_out, c == 3);
            chk("pump_high", if_pump_high, c == 2);
        end
        $display("test static config done");
        // Speed-up run of four comparisons, gain select high but ignored after
        put({3'h0, 1'b0, 1'b1, 1'b1, 15'h0004, 3'h0});
        put({7'h00, 14'h0004, 3'h2});
        put({4'h0, fb, 3'h1});
        chk("pin_out", if_speedup_pin_out, 1);
        repeat (400) @(posedge ref_clk);
        #1;
        chk("pin_out", if_speedup_pin_out, 0);
        chk("pump_high", if_pump_high, 0);
        @(posedge ref_clk) if_enable_pin <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        chk("if_sleep_bit_state", if_sleep_bit_state, 1);
        chk("fb_bias", if_fb_bias_en, 0);
        chk("ref_bias", if_ref_bias_en, 0);
        @(posedge ref_clk) if_enable_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        chk("ref_bias", if_ref_bias_en, 1);
        put(24'h000106); // Synchronous sleep entry
        put({1'b1, 3'h0, fb ^ 17'h00005, 3'h1});
        // Entry waits for the pulse in progress, at most one feedback period
        for (int w = 0; w < 3000 && !if_sleep_bit_state; w++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("if_sleep_bit_state", if_sleep_bit_state, 1);
        chk("swallow", if_swallow_count, fb[2:0] ^ 3'h5);
        $display("test speed-up and sleep done");
        // Main ratios, denominator 32 or more in fractional mode
        for (int k = 0; k < 6; k++) begin
            {r, d, f, n} = 36'($random(seed));
            r = (r == 9'h000) ? 9'h001 : r;
            d = (d < 7'd32) ? {6'h00, d[0] & ~k[0]} : d;
            @(posedge ref_clk) main_mode_select <= k[0];
            put({5'h00, r, d, 3'h3});
            put({1'b0, n, f, 3'h4});
            chk("main_ratio", main_ratio, exp_ratio(k[0]));
            chk("main_pd", main_pd_state, 0);
        end
        $display("test main ratio done");
        stop_test();
    end
endmodule : dsd_ctrl_tb
`default_nettype wire
